// File: hdl/sacc_defs.svh
// Constants for the converter control block: field positions, resets, timing.
`ifndef SACC_DEFS_SVH
`define SACC_DEFS_SVH
`define SACC_CLK_HZ 50000000
`define SACC_MAX_SPS 100000
`define SACC_MIN_CONV_CYC ((`SACC_CLK_HZ + `SACC_MAX_SPS - 1) / `SACC_MAX_SPS)
`define SACC_SAR_BITS 12
`define SACC_TRACK_CLKS 3
`define SACC_CONV_CLKS 16
`define SACC_DIV_RESET 5'h1F
`define SACC_GAIN_RESET 3'h0
`define SACC_PAIR_RESET 4'h0
`define SACC_CHAN_RESET 4'h0
`define SACC_TEMP_BIT 3
`define SACC_MODE_SW 2'h0
`define SACC_MODE_T3 2'h1
`define SACC_MODE_STROBE 2'h2
`define SACC_MODE_T2 2'h3
`endif

// File: hdl/sacc_pkg.sv
// Types for the converter control block.
package sacc_pkg;
    typedef enum logic [2:0] {
        SACC_OFF,
        SACC_IDLE,
        SACC_TRACK,
        SACC_CONVERT
    } sacc_state_e;
    typedef enum logic [2:0] {
        SACC_GAIN_HALF,
        SACC_GAIN_1,
        SACC_GAIN_2,
        SACC_GAIN_4,
        SACC_GAIN_8,
        SACC_GAIN_16
    } sacc_gain_e;
endpackage

// File: hdl/sacc_clk_div.sv
// Conversion clock tick generator dividing the system clock.
`timescale 1ns/1ps
`include "sacc_defs.svh"
module sacc_clk_div #(
    parameter int DIV_W = 5
) (
    input wire logic clk,               // System clock
    input wire logic reset,             // Async reset, high
    input wire logic run,               // Divider runs while high
    input wire logic [DIV_W-1:0] div,   // Divide value minus one
    output logic tick                   // One-cycle conversion clock tick
);
    logic [DIV_W-1:0] cnt_ff;

    // ----------------------------------------
    // Divider counter
    // ----------------------------------------
    // Tick once every div+1 system clocks; restarts when stopped
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_ff <= '0;
        end else if (!run || cnt_ff >= div) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    assign tick = run && (cnt_ff >= div); // [RULE6] [RULE19]

    tick_period_a: assert property (@(posedge clk) disable iff (reset)
        tick && run && $stable(div) |=> !tick || div == '0) // [RULE19]
        else $error("conversion tick repeated too early");
endmodule

// File: hdl/sacc_top.sv
// Conversion control for a 12-bit successive-approximation converter.
// Function
// (RULE1) Converter, track-and-hold and gain run only while enable bit is one.
// (RULE2) Nine channels: eight external inputs plus the temperature sensor.
// (RULE3) Adjacent pairs selectable differential or single-ended; single-ended after reset.
// (RULE4) Gain field selects 0.5, 1, 2, 4, 8, 16; unity after reset.
// (RULE5) Twelve-bit successive approximation, throughput no more than 100 ksps; not limited here, a conversion at divide zero takes 16 system clocks.
// (RULE6) Conversion clock divides the system clock by the divide field plus one.
// (RULE7) Start on software busy write, timer three, strobe rise, or timer two.
// (RULE8) Busy reads one throughout a conversion, zero after completion.
// (RULE9) Busy falling edge sets the done flag and raises enabled interrupt.
// (RULE10) Result placed in high and low registers, left or right justified.
// (RULE11) Software clears done, writes busy, polls done, then reads result.
// (RULE12) Track mode zero tracks continuously when no conversion runs.
// (RULE13) Track mode one precedes conversion with exactly three conversion clocks tracking.
// (RULE14) Low-power mode with strobe: track while strobe low, convert on rise.
// (RULE15) Tracking disabled while the chip is in standby or sleep.
// (RULE16) Selected temperature sensor feeds the gain stage with programmed gain.
// (RULE17) Start mode codes 00, 01, 10, 11 pick software, timer3, strobe, timer2.
// (RULE18) Hardware never clears the done flag; software must.
// (RULE19) Divide field equals system clock over conversion clock, minus one.
// (RULE20) Gain 000=1, 001=2, 010=4, 011=8, 10x=16, 11x=0.5.
// (RULE21) Start events during a conversion are ignored.
// (RULE22) Unused bits of the result pair read zero in both justifications.
`timescale 1ns/1ps
`include "sacc_defs.svh"
module sacc_top #(
    parameter int RES_W = `SACC_SAR_BITS,      // Result width
    parameter int CONV_CLKS = `SACC_CONV_CLKS  // Conversion clocks per result
) (
    input wire logic clk,                      // System clock, 50 MHz
    input wire logic reset,                    // Async reset, high
    input wire logic converter_enable_bit,     // Subsystem enable
    input wire logic track_mode_bit,           // Low-power tracking when high
    input wire logic start_mode_hi,            // Start source select, high bit
    input wire logic start_mode_lo,            // Start source select, low bit
    input wire logic left_justify_bit,         // Left-justify result
    input wire logic [4:0] clock_divide_field, // System over conversion clock minus one
    input wire logic [2:0] gain_select_field,  // Gain code
    input wire logic [3:0] channel_address_field, // Channel select
    input wire logic [3:0] pair_config_bits,   // Pair differential bits
    input wire logic busy_write_one,           // Pulse: software writes one to busy
    input wire logic done_flag_clear,          // Pulse: software writes zero to done
    input wire logic done_irq_enable,          // Completion interrupt enable
    input wire logic timer3_overflow,          // Third-timer overflow pulse
    input wire logic timer2_overflow,          // Second-timer overflow pulse
    input wire logic ext_convert_strobe,       // External start strobe
    input wire logic chip_standby,             // Chip in standby or sleep
    input wire logic comparator_in,            // SAR comparator result from analog
    output logic analog_power_on,              // Converter, hold and gain powered
    output logic track_active,                 // Hold switch tracking
    output logic sar_sample,                   // Hold switch open, converting
    output logic [RES_W-1:0] sar_trial,        // DAC trial word
    output logic [3:0] mux_pos_sel,            // Positive input: 0-7 pins, 8 temp
    output logic [3:0] mux_neg_sel,            // Negative input: odd pins 1, 3, 5, 7, 15 ground
    output logic mux_differential,             // Selected channel is a differential pair
    output sacc_pkg::sacc_gain_e gain_setting, // Decoded gain
    output logic conversion_busy_bit,          // Conversion in progress
    output logic conversion_done_flag,         // Sticky completion flag
    output logic done_irq,                     // Interrupt request
    output logic [7:0] result_high_reg,        // Result upper byte
    output logic [7:0] result_low_reg          // Result lower byte
);
    localparam int CW = $clog2(CONV_CLKS + `SACC_TRACK_CLKS + 1);

    sacc_pkg::sacc_state_e state_ff;
    logic [CW-1:0] clks_ff;
    logic [RES_W-1:0] data_ff;
    logic strobe_d_ff;
    logic busy_d_ff;
    logic done_ff;
    logic [15:0] result_ff;
    logic [1:0] mode;
    logic tick;
    logic start_evt;
    logic strobe_rise;
    logic divider_run;

    assign mode = {start_mode_hi, start_mode_lo};
    assign strobe_rise = ext_convert_strobe && !strobe_d_ff;

    // ----------------------------------------
    // Start source selection
    // ----------------------------------------
    // Only the selected source counts; others are ignored
    always_comb begin
        unique case (mode)
            `SACC_MODE_SW: start_evt = busy_write_one;         // [RULE7] [RULE17]
            `SACC_MODE_T3: start_evt = timer3_overflow;        // [RULE7] [RULE17]
            `SACC_MODE_STROBE: start_evt = strobe_rise;        // [RULE7] [RULE14]
            `SACC_MODE_T2: start_evt = timer2_overflow;        // [RULE7] [RULE17]
        endcase
    end

    // Strobe edge memory; kept while disabled so no false edge on enable
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            strobe_d_ff <= 1'b0;
        end else begin
            strobe_d_ff <= ext_convert_strobe;
        end
    end

    // ----------------------------------------
    // Conversion clock
    // ----------------------------------------
    assign divider_run = (state_ff == sacc_pkg::SACC_TRACK) ||
                         (state_ff == sacc_pkg::SACC_CONVERT);

    sacc_clk_div #(.DIV_W(5)) u_div (
        .clk(clk),
        .reset(reset),
        .run(divider_run),
        .div(clock_divide_field),
        .tick(tick)
    );

    // ----------------------------------------
    // Conversion sequencer
    // ----------------------------------------
    // Strobe starts skip the fixed track period: tracking already ran while low
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff <= sacc_pkg::SACC_OFF;
            clks_ff <= '0;
        end else if (!converter_enable_bit) begin
            state_ff <= sacc_pkg::SACC_OFF;                    // [RULE1]
            clks_ff <= '0;
        end else begin
            unique case (state_ff)
                sacc_pkg::SACC_OFF: begin
                    state_ff <= sacc_pkg::SACC_IDLE;
                end
                sacc_pkg::SACC_IDLE: begin
                    clks_ff <= '0;
                    if (start_evt && track_mode_bit && mode != `SACC_MODE_STROBE) begin
                        state_ff <= sacc_pkg::SACC_TRACK;     // [RULE13]
                    end else if (start_evt) begin
                        state_ff <= sacc_pkg::SACC_CONVERT;
                    end
                end
                sacc_pkg::SACC_TRACK: begin
                    if (tick) begin
                        if (clks_ff == CW'(`SACC_TRACK_CLKS - 1)) begin
                            clks_ff <= '0;
                            state_ff <= sacc_pkg::SACC_CONVERT; // [RULE13]
                        end else begin
                            clks_ff <= clks_ff + 1'b1;
                        end
                    end
                end
                sacc_pkg::SACC_CONVERT: begin
                    // Further starts are not looked at here
                    if (tick) begin                            // [RULE21]
                        if (clks_ff == CW'(CONV_CLKS - 1)) begin
                            clks_ff <= '0;
                            state_ff <= sacc_pkg::SACC_IDLE;
                        end else begin
                            clks_ff <= clks_ff + 1'b1;
                        end
                    end
                end
                default: begin
                    state_ff <= sacc_pkg::SACC_OFF;
                end
            endcase
        end
    end

    // Successive approximation: one bit decided per conversion clock
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            data_ff <= '0;
        end else if (state_ff != sacc_pkg::SACC_CONVERT) begin
            data_ff <= '0;
        end else if (tick && clks_ff < CW'(RES_W)) begin
            data_ff[RES_W-1-int'(clks_ff)] <= comparator_in; // [RULE5]
        end
    end

    // Trial word: decided bits, the bit under test set, rest clear
    always_comb begin
        sar_trial = data_ff;
        if (state_ff == sacc_pkg::SACC_CONVERT && clks_ff < CW'(RES_W)) begin
            sar_trial[RES_W-1-int'(clks_ff)] = 1'b1;
        end
    end

    // ----------------------------------------
    // Busy, done flag and result
    // ----------------------------------------
    assign conversion_busy_bit = (state_ff == sacc_pkg::SACC_TRACK) ||
                                 (state_ff == sacc_pkg::SACC_CONVERT); // [RULE8]

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busy_d_ff <= 1'b0;
        end else begin
            busy_d_ff <= conversion_busy_bit;
        end
    end

    // Set wins over a clear landing in the same cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            done_ff <= 1'b0;
        end else if (busy_d_ff && !conversion_busy_bit) begin
            done_ff <= 1'b1;                                   // [RULE9]
        end else if (done_flag_clear) begin
            done_ff <= 1'b0;                                   // [RULE18] [RULE11]
        end
    end

    assign conversion_done_flag = done_ff;
    assign done_irq = done_ff && done_irq_enable;              // [RULE9]

    // Captured at the last conversion clock, justified per the current setting
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            result_ff <= 16'h0000;
        end else if (state_ff == sacc_pkg::SACC_CONVERT && tick &&
                     clks_ff == CW'(CONV_CLKS - 1)) begin
            if (left_justify_bit) begin
                result_ff <= {data_ff, {(16 - RES_W){1'b0}}}; // [RULE10] [RULE22]
            end else begin
                result_ff <= {{(16 - RES_W){1'b0}}, data_ff}; // [RULE10] [RULE22]
            end
        end
    end

    assign result_high_reg = result_ff[15:8];
    assign result_low_reg = result_ff[7:0];

    // ----------------------------------------
    // Analog front end control
    // ----------------------------------------
    assign analog_power_on = converter_enable_bit;             // [RULE1]
    assign sar_sample = (state_ff == sacc_pkg::SACC_CONVERT);

    // Tracking: continuous when idle, or timed, or strobe-low in low-power mode
    always_comb begin
        track_active = 1'b0;
        if (converter_enable_bit && !chip_standby) begin       // [RULE15]
            if (!track_mode_bit) begin
                track_active = (state_ff == sacc_pkg::SACC_IDLE); // [RULE12]
            end else if (mode == `SACC_MODE_STROBE) begin
                track_active = (state_ff == sacc_pkg::SACC_IDLE) &&
                               !ext_convert_strobe;            // [RULE14]
            end else begin
                track_active = (state_ff == sacc_pkg::SACC_TRACK); // [RULE13]
            end
        end
    end

    // Channel routing: bit 3 selects the sensor, else pair bits decide
    always_comb begin
        mux_pos_sel = {1'b0, channel_address_field[2:0]};
        mux_neg_sel = 4'hF;
        mux_differential = 1'b0;
        if (channel_address_field[`SACC_TEMP_BIT]) begin
            mux_pos_sel = 4'h8;                                // [RULE2] [RULE16]
        end else if (pair_config_bits[channel_address_field[2:1]]) begin
            mux_pos_sel = {1'b0, channel_address_field[2:1], 1'b0}; // [RULE3]
            mux_neg_sel = {1'b0, channel_address_field[2:1], 1'b1};
            mux_differential = 1'b1;
        end
    end

    // Gain decode; sensor path shares the same gain
    always_comb begin
        unique casez (gain_select_field)
            3'b000: gain_setting = sacc_pkg::SACC_GAIN_1;      // [RULE4] [RULE20]
            3'b001: gain_setting = sacc_pkg::SACC_GAIN_2;      // [RULE20]
            3'b010: gain_setting = sacc_pkg::SACC_GAIN_4;      // [RULE20]
            3'b011: gain_setting = sacc_pkg::SACC_GAIN_8;      // [RULE20]
            3'b10?: gain_setting = sacc_pkg::SACC_GAIN_16;     // [RULE20]
            3'b11?: gain_setting = sacc_pkg::SACC_GAIN_HALF;   // [RULE20]
        endcase
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    off_when_disabled_a: assert property (@(posedge clk) disable iff (reset)
        !converter_enable_bit |=> !conversion_busy_bit) // [RULE1]
        else $error("busy while disabled");
    done_on_fall_a: assert property (@(posedge clk) disable iff (reset)
        $fell(conversion_busy_bit) |=> conversion_done_flag) // [RULE9]
        else $error("done flag not set after busy fell");
    done_sticky_a: assert property (@(posedge clk) disable iff (reset)
        conversion_done_flag && !done_flag_clear |=> conversion_done_flag) // [RULE18]
        else $error("done flag cleared without software");
    busy_start_sw_a: assert property (@(posedge clk) disable iff (reset)
        sacc_pkg::SACC_IDLE == state_ff && mode == 2'h0 && busy_write_one
        && converter_enable_bit |=> conversion_busy_bit) // [RULE7]
        else $error("software start missed");
    track_len_a: assert property (@(posedge clk) disable iff (reset)
        $rose(state_ff == sacc_pkg::SACC_TRACK) && clock_divide_field == 5'h00
        && converter_enable_bit ##1 converter_enable_bit[*2]
        |=> state_ff == sacc_pkg::SACC_CONVERT) // [RULE13]
        else $error("track interval not three clocks");
    busy_ignores_start_a: assert property (@(posedge clk) disable iff (reset)
        sar_sample && !tick && converter_enable_bit |=> sar_sample) // [RULE21]
        else $error("conversion disturbed");
    standby_no_track_a: assert property (@(posedge clk) disable iff (reset)
        chip_standby |-> !track_active) // [RULE15]
        else $error("tracking during standby");
    justify_zero_a: assert property (@(posedge clk) disable iff (reset)
        $changed(result_ff) && !left_justify_bit |-> result_high_reg[7:4] == 4'h0) // [RULE22]
        else $error("unused result bits set");
    temp_route_a: assert property (@(posedge clk) disable iff (reset)
        channel_address_field[3] |-> mux_pos_sel == 4'h8 && !mux_differential) // [RULE16]
        else $error("sensor not routed");

    sw_conv_c: cover property (@(posedge clk) disable iff (reset)
        $fell(conversion_busy_bit) && mode == 2'h0);
    lp_track_c: cover property (@(posedge clk) disable iff (reset)
        state_ff == sacc_pkg::SACC_TRACK && track_mode_bit);
    strobe_conv_c: cover property (@(posedge clk) disable iff (reset)
        strobe_rise && mode == 2'h2 && state_ff == sacc_pkg::SACC_IDLE);
    diff_c: cover property (@(posedge clk) disable iff (reset) mux_differential);
endmodule

// File: verification/sacc_analog_model.sv
// Analog side model: held input level seen through an ideal comparator.
`timescale 1ns/1ps
module sacc_analog_model (
    input wire logic [11:0] sar_trial, // Trial word from the converter
    input wire logic [11:0] level,     // Held input expressed as an ideal code
    input wire logic hold_open,        // High while the converter is deciding bits
    output logic comparator_in         // High while converting and input is at or above the trial
);
    // Outside conversion the answer is inverted, so a design that reads it early gets garbage
    assign comparator_in = hold_open ? (level >= sar_trial) : (level < sar_trial);
endmodule

// File: verification/sacc_top_test.sv
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
module sacc_top_test;
    // ----------------------------------------
    // Signals and tables
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] mode;
        logic track;
        logic left;
        logic [4:0] div;
        logic [11:0] level;
        logic [15:0] result;
        logic [7:0] cycles;
    } sacc_row_s;
    logic clk, reset, en, tmode, sm_hi, sm_lo, ljust, busy_wr, done_clr, irq_en;
    logic t3_ovf, t2_ovf, strobe, standby, cmp, pwr, track, sample, diff, busy, done, irq;
    logic [4:0] div;
    logic [2:0] gain;
    logic [3:0] chan, pair, pos_sel, neg_sel;
    logic [11:0] trial, level;
    logic [7:0] res_hi, res_lo;
    sacc_pkg::sacc_gain_e gain_out;
    int fails, cmp_count, cyc;
    sacc_row_s rows [8];
    logic [16:0] mux_tab [5];
    sacc_pkg::sacc_gain_e gexp [8];
    // ----------------------------------------
    // Design and analog side
    // ----------------------------------------
    sacc_top dut (.clk(clk), .reset(reset), .converter_enable_bit(en), .track_mode_bit(tmode),
        .start_mode_hi(sm_hi), .start_mode_lo(sm_lo), .left_justify_bit(ljust),
        .clock_divide_field(div), .gain_select_field(gain), .channel_address_field(chan),
        .pair_config_bits(pair), .busy_write_one(busy_wr), .done_flag_clear(done_clr),
        .done_irq_enable(irq_en), .timer3_overflow(t3_ovf), .timer2_overflow(t2_ovf),
        .ext_convert_strobe(strobe), .chip_standby(standby), .comparator_in(cmp),
        .analog_power_on(pwr), .track_active(track), .sar_sample(sample), .sar_trial(trial),
        .mux_pos_sel(pos_sel), .mux_neg_sel(neg_sel), .mux_differential(diff),
        .gain_setting(gain_out), .conversion_busy_bit(busy), .conversion_done_flag(done),
        .done_irq(irq), .result_high_reg(res_hi), .result_low_reg(res_lo));
    sacc_analog_model model (.sar_trial(trial), .level(level), .hold_open(sample),
        .comparator_in(cmp));
    // 50 MHz system clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Fires one start from the chosen source and counts busy cycles; extra retries mid-way
    task automatic convert(input logic [1:0] mode, input logic extra, output int n);
        @(negedge clk);
        {sm_hi, sm_lo} = mode;
        busy_wr = (mode == 2'h0);
        t3_ovf = (mode == 2'h1);
        strobe = (mode == 2'h2);
        t2_ovf = (mode == 2'h3);
        @(negedge clk);
        {busy_wr, t3_ovf, t2_ovf} = 3'h0;
        n = 0;
        while (busy === 1'b1 && n < 2000) begin
            n++;
            busy_wr = extra && (n == 5);
            @(negedge clk);
        end
        {strobe, busy_wr} = 2'h0;
    endtask
    // ----------------------------------------
    // Watchdog: whole run is a few hundred cycles
    // ----------------------------------------
    initial begin
        #400000;
        fails++;
        $display("MISMATCH at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
        tally_and_finish();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {reset, en, tmode, sm_hi, sm_lo, ljust, busy_wr, done_clr, irq_en} = 9'h180;
        {t3_ovf, t2_ovf, strobe, standby} = 4'h0;
        {div, gain, chan, pair, level} = {5'h00, 3'h0, 4'h0, 4'h0, 12'h000};
        fails = 0;
        cmp_count = 0;
        // Row: mode, track, left, div, level, result pair, busy cycles
        rows = '{{2'h0, 1'b0, 1'b0, 5'h00, 12'hABC, 16'h0ABC, 8'h10},
                 {2'h1, 1'b0, 1'b1, 5'h00, 12'h123, 16'h1230, 8'h10},
                 {2'h2, 1'b0, 1'b0, 5'h01, 12'hFFF, 16'h0FFF, 8'h20},
                 {2'h3, 1'b0, 1'b1, 5'h00, 12'h000, 16'h0000, 8'h10},
                 {2'h0, 1'b1, 1'b0, 5'h00, 12'h800, 16'h0800, 8'h13},
                 {2'h1, 1'b1, 1'b1, 5'h02, 12'h001, 16'h0010, 8'h39},
                 {2'h2, 1'b1, 1'b0, 5'h00, 12'h555, 16'h0555, 8'h10},
                 {2'h3, 1'b1, 1'b1, 5'h00, 12'hFFE, 16'hFFE0, 8'h13}};
        // Pair bits, channel, positive, negative, differential
        mux_tab = '{{4'h0, 4'h3, 4'h3, 4'hF, 1'b0}, {4'h1, 4'h0, 4'h0, 4'h1, 1'b1},
                    {4'h8, 4'h6, 4'h6, 4'h7, 1'b1}, {4'h8, 4'h5, 4'h5, 4'hF, 1'b0},
                    {4'hF, 4'h8, 4'h8, 4'hF, 1'b0}};
        gexp = '{sacc_pkg::SACC_GAIN_1, sacc_pkg::SACC_GAIN_2, sacc_pkg::SACC_GAIN_4,
                 sacc_pkg::SACC_GAIN_8, sacc_pkg::SACC_GAIN_16, sacc_pkg::SACC_GAIN_16,
                 sacc_pkg::SACC_GAIN_HALF, sacc_pkg::SACC_GAIN_HALF};
        repeat (5) @(negedge clk);
        check(16'({busy, done}), 16'h0);
        check({res_hi, res_lo}, 16'h0000);
        check(16'(gain_out), 16'(sacc_pkg::SACC_GAIN_1));
        check(16'(diff), 16'h0);
        reset = 1'b0;
        repeat (2) @(negedge clk);
        // Table of ordinary conversions, every start source in both tracking modes
        foreach (rows[i]) begin
            {tmode, ljust, div, level} = {rows[i].track, rows[i].left, rows[i].div, rows[i].level};
            {sm_hi, sm_lo} = rows[i].mode;
            irq_en = i[0];
            done_clr = 1'b1;
            @(negedge clk);
            done_clr = 1'b0;
            @(negedge clk);
            check(16'(done), 16'h0);
            check(16'(track), 16'(!rows[i].track || rows[i].mode == 2'h2));
            convert(rows[i].mode, 1'b0, cyc);
            check(16'(cyc), 16'(rows[i].cycles));
            check({res_hi, res_lo}, rows[i].result);
            @(negedge clk);
            check({14'h0, done, irq}, {14'h0, 1'b1, i[0]});
            repeat (3) @(negedge clk);
            check(16'(done), 16'h1);
        end
        // Gain decode for every code, with the temperature sensor selected
        chan = 4'h8;
        for (int g = 0; g < 8; g++) begin
            gain = 3'(g);
            @(negedge clk);
            check(16'(gain_out), 16'(gexp[g]));
            check(16'(pos_sel), 16'h8);
        end
        // Selector routing, single-ended and paired
        foreach (mux_tab[i]) begin
            {pair, chan} = mux_tab[i][16:9];
            @(negedge clk);
            check({7'h0, pos_sel, neg_sel, diff}, 16'(mux_tab[i][8:0]));
        end
        // Standby stops tracking
        {tmode, standby} = 2'h1;
        @(negedge clk);
        check(16'(track), 16'h0);
        standby = 1'b0;
        // Retry during a conversion is ignored, and no second conversion follows
        {div, level, ljust} = {5'h00, 12'h3C5, 1'b0};
        convert(2'h0, 1'b1, cyc);
        check(16'(cyc), 16'h10);
        check({res_hi, res_lo}, 16'h03C5);
        repeat (3) @(negedge clk);
        check(16'(busy), 16'h0);
        // Sources not selected by the mode are ignored
        {sm_hi, sm_lo, busy_wr, t2_ovf, strobe} = 5'b01111;
        @(negedge clk);
        {busy_wr, t2_ovf} = 2'h0;
        repeat (2) @(negedge clk);
        check(16'(busy), 16'h0);
        strobe = 1'b0;
        // Dropping enable mid-conversion aborts; busy still falls, so the flag is set
        {done_clr, sm_hi, sm_lo, busy_wr, level} = {4'b1001, 12'h111};
        @(negedge clk);
        {done_clr, busy_wr} = 2'h0;
        repeat (4) @(negedge clk);
        check(16'(busy), 16'h1);
        check(16'(sample), 16'h1);
        check(16'(trial), 16'h0180);
        en = 1'b0;
        repeat (3) @(negedge clk);
        check({13'h0, pwr, busy, done}, 16'h1);
        check({res_hi, res_lo}, 16'h03C5);
        busy_wr = 1'b1;
        @(negedge clk);
        busy_wr = 1'b0;
        @(negedge clk);
        check(16'(busy), 16'h0);
        en = 1'b1;
        repeat (2) @(negedge clk);
        check(16'(pwr), 16'h1);
        tally_and_finish();
    end
endmodule
